//--- verilog/acs_params.svh
// Register offsets, field masks, reset values and result limits of the measurement register group.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

`define ACS_OFF_DIS_A      8'h2F
`define ACS_OFF_DIS_B      8'h30
`define ACS_OFF_IBUS_HI    8'h31
`define ACS_OFF_IBUS_LO    8'h32
`define ACS_OFF_IBAT_HI    8'h33
`define ACS_OFF_IBAT_LO    8'h34
`define ACS_OFF_INPUT_POWER_BUS_HI    8'h35
`define ACS_OFF_INPUT_POWER_BUS_LO    8'h36

`define ACS_DIS_A_WMASK    8'hFE
`define ACS_DIS_B_WMASK    8'hF0
`define ACS_DIS_A_FIRST    7
`define ACS_DIS_A_COUNT    7
`define ACS_DIS_B_FIRST    7
`define ACS_DIS_B_COUNT    4
`define ACS_RST_DIS        8'h00
`define ACS_RST_RESULT     16'h0000
`define ACS_UNMAPPED_READ  8'h00

`define ACS_IBUS_MAX       16'h1388
`define ACS_IBUS_MIN       16'hEC78
`define ACS_IBAT_MAX       16'h1F40
`define ACS_IBAT_MIN       16'hE0C0
`define ACS_INPUT_POWER_BUS_MAX       16'h7530
`define ACS_INPUT_POWER_BUS_MIN       16'h0000

`endif

//--- verilog/acs_pkg.sv
// Types shared by the measurement register group modules.
package acs_pkg;

  typedef enum logic [3:0] {
    ACS_CH_BUS_CUR,
    ACS_CH_BAT_CUR,
    ACS_CH_BUS_VOLT,
    ACS_CH_BAT_VOLT,
    ACS_CH_SYS_VOLT,
    ACS_CH_THERM,
    ACS_CH_DIE_TEMP,
    ACS_CH_DATA_PLUS,
    ACS_CH_DATA_MINUS,
    ACS_CH_SECOND_SRC,
    ACS_CH_FIRST_SRC
  } acs_chan_t;

  typedef enum logic [1:0] {
    ACS_SEQ_IDLE,
    ACS_SEQ_WAIT
  } acs_seq_t;

  typedef struct packed {
    acs_seq_t    seq;
    acs_chan_t   chan;
    logic        start;
    logic        busy;
    logic        pass_done;
    logic [7:0]  dis_a;
    logic [7:0]  dis_b;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  snap;
    logic [7:0]  snap_addr;
    logic        snap_vld;
  } acs_state_t;

  typedef struct packed {
    logic [15:0] value;
  } acs_res_state_t;

endpackage

//--- verilog/acs_res_if.sv
// Carrier between the sequencer and one measurement result holder.
`timescale 1ns/1ps
`default_nettype none
interface acs_res_if;
  logic        load;
  logic [15:0] data;
  logic [15:0] value;
  modport writer (output load, output data, input value);
  modport keeper (input load, input data, output value);
endinterface
`default_nettype wire

//--- verilog/acs_result.sv
// One 16-bit two's complement measurement result with range saturation.
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module acs_result #(
  parameter logic [15:0] MAX_VAL = `ACS_IBUS_MAX,
  parameter logic [15:0] MIN_VAL = `ACS_IBUS_MIN
) (
  input  wire logic     clock_i,
  input  wire logic     srst_i,
  acs_res_if.keeper     res
);

  acs_pkg::acs_res_state_t state_ff;
  acs_pkg::acs_res_state_t nxt_state;

  always_comb begin
    nxt_state = state_ff;
    // The sign is taken as the converter gives it; the signed value is clamped to MIN_VAL..MAX_VAL.
    if (res.load) begin
      if ($signed(res.data) > $signed(MAX_VAL)) begin
        nxt_state.value = MAX_VAL;
      end else if ($signed(res.data) < $signed(MIN_VAL)) begin
        nxt_state.value = MIN_VAL;
      end else begin
        nxt_state.value = res.data;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff.value <= `ACS_RST_RESULT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign res.value = state_ff.value;

endmodule
`default_nettype wire

//--- verilog/acs_meas_regs.sv
// Channel-disable registers, result registers and conversion sequencer of the monitor converter.
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
// Operation
// - First disable register bits 7..1 gate channels.
// - Second disable register bits 7..4 gate channels.
// - Reserved bits read zero, ignore writes.
// - Disables clear on reset and register-reset command.
// - Results are 16-bit, read-only, zero after reset.
// - Bus current positive into mid power node.
// - Bus current 1 mA per bit, 5000 mA.
// - Battery current positive while charging.
// - Battery current 1 mA per bit, 8000 mA.
// - Bus voltage 1 mV per bit, 30000 mV.
// - Disable registers at 0x2F and 0x30.
// - Results at 0x31, 0x33, 0x35, two bytes.
// - Global enable gates all conversions.
// - Rate selects continuous or one-shot pass.
module acs_meas_regs #(
  parameter int NUM_CHAN = 11
) (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_rd_i,
  input  wire logic        reg_reset_cmd_i,
  input  wire logic        adc_en_i,
  input  wire logic        adc_one_shot_i,
  input  wire logic        conv_done_i,
  input  wire logic [15:0] conv_data_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rvalid_o,
  output logic             conv_start_o,
  output logic [3:0]       conv_chan_o,
  output logic [10:0]      chan_off_o,
  output logic             adc_busy_o,
  output logic             pass_done_o
);

  acs_pkg::acs_state_t state_ff;
  acs_pkg::acs_state_t nxt_state;

  acs_res_if ibus_if ();
  acs_res_if ibat_if ();
  acs_res_if input_power_bus_if ();

  logic [NUM_CHAN-1:0] off_vec;
  logic [4:0]          hit_next;
  logic [4:0]          hit_first;
  logic                take_result;

  // Lowest enabled channel at or above the start index; the top bit flags a hit.
  function automatic logic [4:0] find_from(input logic [NUM_CHAN-1:0] off,
                                           input logic [4:0] from);
    logic [4:0] res;
    res = 5'h00;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if ((5'(i) >= from) && !off[i]) begin
        res = {1'b1, 4'(i)};
      end
    end
    return res;
  endfunction

  // Channel index order follows the bit order of the two disable registers.
  always_comb begin
    off_vec = '0;
    for (int i = 0; i < `ACS_DIS_A_COUNT; i++) begin
      off_vec[i] = state_ff.dis_a[`ACS_DIS_A_FIRST - i];
    end
    for (int j = 0; j < `ACS_DIS_B_COUNT; j++) begin
      off_vec[`ACS_DIS_A_COUNT + j] = state_ff.dis_b[`ACS_DIS_B_FIRST - j];
    end
  end

  assign hit_next  = find_from(off_vec, 5'({1'b0, state_ff.chan}) + 5'h01);
  assign hit_first = find_from(off_vec, 5'h00);

  // A result that finishes after its channel was disabled is dropped, so the old value holds.
  assign take_result = (state_ff.seq == acs_pkg::ACS_SEQ_WAIT) && conv_done_i && adc_en_i
                       && !off_vec[state_ff.chan];

  assign ibus_if.load = take_result && (state_ff.chan == acs_pkg::ACS_CH_BUS_CUR);
  assign ibat_if.load = take_result && (state_ff.chan == acs_pkg::ACS_CH_BAT_CUR);
  assign input_power_bus_if.load = take_result && (state_ff.chan == acs_pkg::ACS_CH_BUS_VOLT);
  // The converter already reports signed values in the documented direction and scale.
  assign ibus_if.data = conv_data_i;
  assign ibat_if.data = conv_data_i;
  assign input_power_bus_if.data = conv_data_i;

  always_comb begin
    nxt_state        = state_ff;
    nxt_state.start  = 1'b0;
    nxt_state.rvalid = 1'b0;

    if (!adc_en_i || !adc_one_shot_i) begin
      nxt_state.pass_done = 1'b0;
    end

    case (state_ff.seq)
      acs_pkg::ACS_SEQ_IDLE: begin
        if (adc_en_i && !(adc_one_shot_i && state_ff.pass_done) && hit_first[4]) begin
          nxt_state.chan  = acs_pkg::acs_chan_t'(hit_first[3:0]);
          nxt_state.start = 1'b1;
          nxt_state.seq   = acs_pkg::ACS_SEQ_WAIT;
        end
      end
      acs_pkg::ACS_SEQ_WAIT: begin
        if (!adc_en_i) begin
          nxt_state.seq = acs_pkg::ACS_SEQ_IDLE;
        end else if (conv_done_i) begin
          if (hit_next[4]) begin
            nxt_state.chan  = acs_pkg::acs_chan_t'(hit_next[3:0]);
            nxt_state.start = 1'b1;
          end else if (!adc_one_shot_i && hit_first[4]) begin
            nxt_state.chan  = acs_pkg::acs_chan_t'(hit_first[3:0]);
            nxt_state.start = 1'b1;
          end else begin
            nxt_state.seq       = acs_pkg::ACS_SEQ_IDLE;
            nxt_state.pass_done = adc_one_shot_i;
          end
        end
      end
      default: begin
        nxt_state.seq = acs_pkg::ACS_SEQ_IDLE;
      end
    endcase
    nxt_state.busy = (nxt_state.seq != acs_pkg::ACS_SEQ_IDLE);

    // The register-reset command wins over a write in the same cycle.
    if (reg_reset_cmd_i) begin
      nxt_state.dis_a = `ACS_RST_DIS;
      nxt_state.dis_b = `ACS_RST_DIS;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `ACS_OFF_DIS_A) begin
        nxt_state.dis_a = reg_wdata_i & `ACS_DIS_A_WMASK;
      end else if (reg_addr_i == `ACS_OFF_DIS_B) begin
        nxt_state.dis_b = reg_wdata_i & `ACS_DIS_B_WMASK;
      end
    end

    // Reading a high byte freezes the matching low byte, so a two-byte read never tears
    // across a conversion update.
    if (reg_rd_i) begin
      nxt_state.rvalid = 1'b1;
      if (reg_addr_i == `ACS_OFF_DIS_A) begin
        nxt_state.rdata = state_ff.dis_a & `ACS_DIS_A_WMASK;
      end else if (reg_addr_i == `ACS_OFF_DIS_B) begin
        nxt_state.rdata = state_ff.dis_b & `ACS_DIS_B_WMASK;
      end else if (reg_addr_i == `ACS_OFF_IBUS_HI) begin
        nxt_state.rdata     = ibus_if.value[15:8];
        nxt_state.snap      = ibus_if.value[7:0];
        nxt_state.snap_addr = `ACS_OFF_IBUS_LO;
        nxt_state.snap_vld  = 1'b1;
      end else if (reg_addr_i == `ACS_OFF_IBAT_HI) begin
        nxt_state.rdata     = ibat_if.value[15:8];
        nxt_state.snap      = ibat_if.value[7:0];
        nxt_state.snap_addr = `ACS_OFF_IBAT_LO;
        nxt_state.snap_vld  = 1'b1;
      end else if (reg_addr_i == `ACS_OFF_INPUT_POWER_BUS_HI) begin
        nxt_state.rdata     = input_power_bus_if.value[15:8];
        nxt_state.snap      = input_power_bus_if.value[7:0];
        nxt_state.snap_addr = `ACS_OFF_INPUT_POWER_BUS_LO;
        nxt_state.snap_vld  = 1'b1;
      end else if (state_ff.snap_vld && (reg_addr_i == state_ff.snap_addr)) begin
        nxt_state.rdata    = state_ff.snap;
        nxt_state.snap_vld = 1'b0;
      end else if (reg_addr_i == `ACS_OFF_IBUS_LO) begin
        nxt_state.rdata = ibus_if.value[7:0];
      end else if (reg_addr_i == `ACS_OFF_IBAT_LO) begin
        nxt_state.rdata = ibat_if.value[7:0];
      end else if (reg_addr_i == `ACS_OFF_INPUT_POWER_BUS_LO) begin
        nxt_state.rdata = input_power_bus_if.value[7:0];
      end else begin
        nxt_state.rdata = `ACS_UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_ff.seq       <= acs_pkg::ACS_SEQ_IDLE;
      state_ff.chan      <= acs_pkg::ACS_CH_BUS_CUR;
      state_ff.start     <= 1'b0;
      state_ff.busy      <= 1'b0;
      state_ff.pass_done <= 1'b0;
      state_ff.dis_a     <= `ACS_RST_DIS;
      state_ff.dis_b     <= `ACS_RST_DIS;
      state_ff.rdata     <= 8'h00;
      state_ff.rvalid    <= 1'b0;
      state_ff.snap      <= 8'h00;
      state_ff.snap_addr <= 8'h00;
      state_ff.snap_vld  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  acs_result #(
    .MAX_VAL (`ACS_IBUS_MAX),
    .MIN_VAL (`ACS_IBUS_MIN)
  ) u_ibus (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .res     (ibus_if.keeper)
  );

  acs_result #(
    .MAX_VAL (`ACS_IBAT_MAX),
    .MIN_VAL (`ACS_IBAT_MIN)
  ) u_ibat (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .res     (ibat_if.keeper)
  );

  acs_result #(
    .MAX_VAL (`ACS_INPUT_POWER_BUS_MAX),
    .MIN_VAL (`ACS_INPUT_POWER_BUS_MIN)
  ) u_input_power_bus (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .res     (input_power_bus_if.keeper)
  );

  assign reg_rdata_o  = state_ff.rdata;
  assign reg_rvalid_o = state_ff.rvalid;
  assign conv_start_o = state_ff.start;
  assign conv_chan_o  = state_ff.chan;
  assign chan_off_o   = off_vec;
  assign adc_busy_o   = state_ff.busy;
  assign pass_done_o  = state_ff.pass_done;

endmodule
`default_nettype wire

//--- tb/acs_meas_regs_properties.sv
// Concurrent checks on the ports of the measurement register group.
`timescale 1ns/1ps
`default_nettype none
module acs_meas_regs_properties #(
  parameter int NUM_CHAN = 11
) (
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic        reg_wr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_rd_i,
  input wire logic        reg_reset_cmd_i,
  input wire logic        adc_en_i,
  input wire logic        adc_one_shot_i,
  input wire logic        conv_done_i,
  input wire logic [15:0] conv_data_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        reg_rvalid_o,
  input wire logic        conv_start_o,
  input wire logic [3:0]  conv_chan_o,
  input wire logic [10:0] chan_off_o,
  input wire logic        adc_busy_o,
  input wire logic        pass_done_o
);
  logic [7:0] wd_q;

  default clocking @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  always_ff @(posedge clock_i) begin
    wd_q <= reg_wdata_i;
  end

  sequence conv_done_s;
    adc_busy_o && conv_done_i && adc_en_i && !adc_one_shot_i;
  endsequence
  sequence start_pulse_s;
    conv_start_o ##1 !conv_start_o;
  endsequence

  rsvd_bit_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h2F |=> !reg_rdata_o[0])
    else $error("reserved bit reads one");
  cmd_clears_a: assert property (reg_reset_cmd_i |=> chan_off_o == 11'h000)
    else $error("reset command kept disables");
  first_map_a: assert property (reg_wr_i && reg_addr_i == 8'h2F && !reg_reset_cmd_i |=>
    chan_off_o[6:0] == {wd_q[1], wd_q[2], wd_q[3], wd_q[4], wd_q[5], wd_q[6], wd_q[7]})
    else $error("first disable map wrong");
  second_map_a: assert property (reg_wr_i && reg_addr_i == 8'h30 && !reg_reset_cmd_i |=>
    chan_off_o[10:7] == {wd_q[4], wd_q[5], wd_q[6], wd_q[7]})
    else $error("second disable map wrong");
  start_enabled_a: assert property (conv_start_o |-> adc_busy_o && !chan_off_o[conv_chan_o])
    else $error("disabled channel started");
  global_off_a: assert property (!adc_en_i |=> !adc_busy_o && !conv_start_o)
    else $error("converter runs while off");
  one_shot_hold_a: assert property (pass_done_o && adc_en_i && adc_one_shot_i |=> !conv_start_o)
    else $error("one-shot pass restarted");
  cont_next_a: assert property (conv_done_s |=> start_pulse_s)
    else $error("continuous mode stalled");
endmodule

bind acs_meas_regs acs_meas_regs_properties #(.NUM_CHAN(NUM_CHAN)) prop_u (.*);
`default_nettype wire

//--- tb/acs_conv_model.sv
// Behavioural converter answering each start with one result after a set delay.
`timescale 1ns/1ps
`default_nettype none
module acs_conv_model (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic [15:0] val_i,
  output logic             done_o,
  output logic [15:0]      data_o
);
  logic       run;
  logic [3:0] cnt;

  // The data bus toggles outside the done pulse, so late sampling reads junk.
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    data_o <= srst_i ? 16'hA5A5 : ~data_o;
    if (srst_i) begin
      run <= 1'b0;
    end else if (start_i) begin
      run <= 1'b1;
      cnt <= lat_i;
    end else if (run && cnt == 4'h0) begin
      run <= 1'b0;
      done_o <= 1'b1;
      data_o <= val_i;
    end else begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/acs_meas_regs_tb.sv
// Self-checking bench of the measurement register group.
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"
module acs_meas_regs_tb;
  logic        clock_i, srst_i, reg_wr_i, reg_rd_i, reg_reset_cmd_i;
  logic        adc_en_i, adc_one_shot_i, conv_done_i, reg_rvalid_o;
  logic        conv_start_o, adc_busy_o, pass_done_o;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [15:0] conv_data_i, conv_val, rd_val;
  logic [3:0]  conv_chan_o, conv_lat;
  logic [10:0] chan_off_o;
  int          fail_count, check_count;

  always #12.5 clock_i = ~clock_i;

  acs_meas_regs #(.NUM_CHAN(11)) dut_u (.*);
  acs_conv_model model_u (.clock_i(clock_i), .srst_i(srst_i), .start_i(conv_start_o),
    .lat_i(conv_lat), .val_i(conv_val), .done_o(conv_done_i), .data_o(conv_data_i));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic cmd);
    @(negedge clock_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_reset_cmd_i = cmd;
    @(negedge clock_i);
    reg_wr_i = 1'b0;
    reg_reset_cmd_i = 1'b0;
  endtask

  task automatic rd8(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    d = {8'h00, reg_rdata_o};
    check(16'(reg_rvalid_o), 16'h0001);
  endtask

  // High byte first; the low byte comes from the snapshot taken with it.
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clock_i);
    reg_addr_i = a + 8'h01;
    d[15:8] = reg_rdata_o;
    @(negedge clock_i);
    reg_rd_i = 1'b0;
    d[7:0] = reg_rdata_o;
  endtask

  task automatic run_pass();
    @(negedge clock_i);
    adc_one_shot_i = 1'b1;
    adc_en_i = 1'b1;
    for (int n = 0; n < 400 && pass_done_o !== 1'b1; n++) @(negedge clock_i);
    check(16'(pass_done_o), 16'h0001);
    adc_en_i = 1'b0;
  endtask

  task automatic t_reset_values();
    for (int a = 8'h2E; a <= 8'h37; a++) begin
      rd8(8'(a), rd_val);
      check(rd_val, 16'h0000);
    end
    check(16'(chan_off_o), 16'h0000);
  endtask

  task automatic t_disable_bits();
    for (int i = 0; i < 7; i++) begin
      wr(8'h2F, 8'(8'h80 >> i), 1'b0);
      check(16'(chan_off_o), 16'h0001 << i);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h30, 8'(8'h80 >> i), 1'b0);
      check(16'(chan_off_o), 16'h0040 | (16'h0080 << i));
    end
    wr(8'h2F, 8'hFF, 1'b0);
    wr(8'h30, 8'hFF, 1'b0);
    wr(8'h31, 8'hFF, 1'b0);
    rd8(8'h2F, rd_val);
    check(rd_val, 16'h00FE);
    rd8(8'h30, rd_val);
    check(rd_val, 16'h00F0);
    rd16(8'h31, rd_val);
    check(rd_val, 16'h0000);
    wr(8'h2F, 8'hFF, 1'b1);
    check(16'(chan_off_o), 16'h0000);
  endtask

  task automatic t_result_ranges();
    logic [15:0] tv [4] = '{16'hFB2E, 16'h1389, 16'hE0BF, 16'h7531};
    logic [15:0] ex [12] = '{16'hFB2E, 16'hFB2E, `ACS_INPUT_POWER_BUS_MIN,
      `ACS_IBUS_MAX, 16'h1389, 16'h1389, `ACS_IBUS_MIN, `ACS_IBAT_MIN,
      `ACS_INPUT_POWER_BUS_MIN, `ACS_IBUS_MAX, `ACS_IBAT_MAX, `ACS_INPUT_POWER_BUS_MAX};
    for (int k = 0; k < 4; k++) begin
      conv_val = tv[k];
      run_pass();
      for (int r = 0; r < 3; r++) begin
        rd16(8'(8'h31 + 2 * r), rd_val);
        check(rd_val, ex[3 * k + r]);
      end
    end
  endtask

  // A slow converter here, and the skipped result must keep its old value.
  task automatic t_skip_disabled();
    wr(8'h2F, 8'h80, 1'b0);
    conv_val = 16'h0123;
    conv_lat = 4'h9;
    run_pass();
    rd16(8'h31, rd_val);
    check(rd_val, `ACS_IBUS_MAX);
    rd16(8'h33, rd_val);
    check(rd_val, 16'h0123);
    wr(8'h2F, 8'h00, 1'b0);
  endtask

  task automatic t_continuous();
    conv_lat = 4'h0;
    @(negedge clock_i);
    adc_one_shot_i = 1'b0;
    adc_en_i = 1'b1;
    repeat (60) @(negedge clock_i);
    conv_val = 16'h0456;
    repeat (60) @(negedge clock_i);
    adc_en_i = 1'b0;
    repeat (2) @(negedge clock_i);
    check(16'(adc_busy_o), 16'h0000);
    rd16(8'h31, rd_val);
    check(rd_val, 16'h0456);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    print_verdict();
  end

  initial begin
    {clock_i, reg_wr_i, reg_rd_i, reg_reset_cmd_i, adc_en_i, adc_one_shot_i} = 6'h00;
    srst_i = 1'b1;
    {reg_addr_i, reg_wdata_i, conv_val} = 32'h0000_0000;
    conv_lat = 4'h2;
    fail_count = 0;
    check_count = 0;
    repeat (3) @(negedge clock_i);
    srst_i = 1'b0;
    t_reset_values();
    t_disable_bits();
    t_result_ranges();
    t_skip_disabled();
    t_continuous();
    print_verdict();
  end
endmodule
`default_nettype wire
